// file: dv/usm_host.sv
// host processor model driving the register port
`timescale 1ns/1ps
module usm_host (
  // clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  // register requests
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb
);
  initial {addr, wdata, wr_stb, rd_stb} = 18'h0_0000;
  // writes hold the strobe for one cycle, then drive inverted address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    v = rdata;
  endtask
endmodule

// file: dv/usm_regs_asserts.sv
// port-level property checks for the status and mode register group
`timescale 1ns/1ps
module usm_regs_asserts #(
  parameter int         FIFO_DEPTH = 256,
  parameter logic [6:0] REVISION   = 7'h15
) (
  // clock, reset and register port
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  // bit clocks and test controls
  input wire logic       tx_clk16_tick,
  input wire logic       tx_bit_clock,
  input wire logic       prescale_bypass,
  input wire logic       mem_test_en,
  input wire logic       scan_test_en,
  input wire logic       pullup_en,
  // live state, mode and receive side
  input wire logic       tx_enabled,
  input wire logic       rx_enabled,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] rx_fifo_count,
  input wire logic       rx_char_ready,
  input wire logic       echo_req,
  input wire logic       echo_active,
  input wire logic       wdog_enable,
  input wire logic [2:0] rx_irq_level,
  input wire logic [5:0] mode_zero_low
);
  logic [7:0] wd_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // write data as it stood at the previous edge
  always_ff @(posedge clk) wd_q <= wdata;
  sequence s_rd(logic [7:0] a);
    rd_stb && addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    wr_stb && addr == a;
  endsequence
  sequence s_lvl0;
    (rx_irq_level == 3'd0 && rx_fifo_count != '0) [*3];
  endsequence
  a_rev_read: assert property (s_rd(8'h67) |=> rdata[6:0] == REVISION)
    else $error("revision field wrong");
  a_eos_unused: assert property (s_rd(8'h12) |=> !rdata[3] && !rdata[1])
    else $error("unused enhanced bits set");
  a_ses_layout: assert property (s_rd(8'h40) |=> rdata[7:6] == 2'b00
    && rdata[5] == $past(tx_enabled) && rdata[4] == $past(rx_enabled)
    && rdata[3] == $past(wdog_enable)) else $error("enable status wrong");
  a_test_bits: assert property (s_wr(8'h77) |=> mem_test_en == wd_q[2]
    && scan_test_en == wd_q[1] && pullup_en == !wd_q[0])
    else $error("test controls wrong");
  a_mode_write: assert property (s_wr(8'h20) |=>
    {wdog_enable, rx_irq_level[2], mode_zero_low} == wd_q)
    else $error("mode write not applied");
  a_bypass_pass: assert property (prescale_bypass |->
    tx_bit_clock == tx_clk16_tick) else $error("bypass tick wrong");
  a_div_gate: assert property (!prescale_bypass && tx_bit_clock |->
    tx_clk16_tick ##1 (!tx_bit_clock || prescale_bypass))
    else $error("divided tick wrong");
  a_level_dflt: assert property (s_lvl0 |-> rx_char_ready)
    else $error("no request with data");
  a_echo_rise: assert property ($rose(echo_req) |=> echo_active)
    else $error("echo not entered");
endmodule

bind usm_regs usm_regs_asserts #(
  .FIFO_DEPTH(FIFO_DEPTH), .REVISION(REVISION)
) u_usm_regs_asserts (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .tx_clk16_tick(tx_clk16_tick),
  .tx_bit_clock(tx_bit_clock), .prescale_bypass(prescale_bypass),
  .mem_test_en(mem_test_en), .scan_test_en(scan_test_en),
  .pullup_en(pullup_en), .tx_enabled(tx_enabled), .rx_enabled(rx_enabled),
  .rx_fifo_count(rx_fifo_count), .rx_char_ready(rx_char_ready),
  .echo_req(echo_req), .echo_active(echo_active),
  .wdog_enable(wdog_enable), .rx_irq_level(rx_irq_level),
  .mode_zero_low(mode_zero_low)
);

// file: dv/usm_regs_bench.sv
// self-checking bench for the status and mode register group
`timescale 1ns/1ps
module usm_regs_bench;
  localparam logic [6:0] REV = 7'h2a;  // arbitrary value
  logic       clk, rst, wr, rd, ir, tt, rt, acc, eq, sst, td, txb, rxb;
  logic       byp, mem, scan, pu, rdy, eact, wdg, irq;
  logic [7:0] addr, wdata, rdata, d, mz, mo;
  logic [4:0] subsystem_enable_status;
  logic [3:0] enhanced_op_status;
  logic [8:0] cnt;
  logic [2:0] lvl;
  logic [5:0] mzl;
  int         errors, comparisons, seed, n, m, i;
  usm_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_stb(wr), .rd_stb(rd));
  usm_regs #(.REVISION(REV)) u_usm_regs (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr), .rd_stb(rd), .rdata(rdata),
    .mode_index_rst(ir), .tx_clk16_tick(tt), .rx_clk16_tick(rt),
    .tx_bit_clock(txb), .rx_bit_clock(rxb), .prescale_bypass(byp),
    .mem_test_en(mem), .scan_test_en(scan), .pullup_en(pu),
    .tx_enabled(subsystem_enable_status[4]), .rx_enabled(subsystem_enable_status[3]), .addr_recog_on(subsystem_enable_status[2]),
    .xon_on(subsystem_enable_status[1]), .xoff_on(subsystem_enable_status[0]), .io_enhanced(enhanced_op_status[3]),
    .ct0_clk_enhanced(enhanced_op_status[2]), .rxtx_clk_enhanced(enhanced_op_status[1]),
    .fifo_lvl_enhanced(enhanced_op_status[0]), .rx_fifo_count(cnt), .rx_fifo_access(acc),
    .rx_char_ready(rdy), .echo_req(eq), .rx_stop_sampled(sst),
    .tx_stop_done(td), .echo_active(eact), .wdog_enable(wdg),
    .rx_irq_level(lvl), .mode_zero_low(mzl), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask
  // k back-to-back 16x ticks on both paths, bit clocks counted
  task automatic ticks(input int k);
    n = 0;
    m = 0;
    repeat (k) begin
      @(posedge clk);
      {tt, rt} <= 2'b11;
      @(negedge clk);
      n += int'(txb);
      m += int'(rxb);
    end
    @(posedge clk);
    {tt, rt} <= 2'b00;
    @(negedge clk);
  endtask
  task automatic setc(input logic [8:0] v);
    @(posedge clk);
    cnt <= v;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    test_done();
  end
  initial begin
    seed = 32'ha171;
    {errors, comparisons} = 64'h0;
    {mz, mo} = 16'h0000;
    rst = 1'b1;
    {ir, tt, rt, acc, eq, sst, td, subsystem_enable_status, enhanced_op_status, cnt} = 25'h000_0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({pu, byp, mem, scan, wdg, irq, eact, rdy}, 8'h80);
    rchk(8'h67, {1'b0, REV});
    rchk(8'h77, 8'h00);
    u_host.wr(8'h67, 8'($random(seed)) | 8'h80);
    rchk(8'h67, {1'b1, REV});
    ticks(5);
    chk(8'(n + m), 8'd10);
    u_host.wr(8'h67, 8'h00);
    ticks(32);
    chk(8'(n + m), 8'd4);
    for (i = 0; i < 8; i++) begin
      u_host.wr(8'h77, 8'(i));
      rchk(8'h77, 8'(i));
      chk({5'h00, mem, scan, !pu}, 8'(i));
    end
    for (i = 0; i < 6; i++) begin
      mz = 8'($random(seed));
      u_host.wr(8'h20, mz);
      chk({wdg, lvl[2], mzl}, mz);
      @(posedge clk);
      {subsystem_enable_status, enhanced_op_status} <= 9'($random(seed));
      u_host.wr(8'h40, 8'hff);
      u_host.wr(8'h12, 8'hff);
      rchk(8'h40, {2'b00, subsystem_enable_status[4:3], mz[7], subsystem_enable_status[2:0]});
      rchk(8'h12, {1'b0, enhanced_op_status[3], 1'b0, enhanced_op_status[2], 1'b0, enhanced_op_status[1],
        1'b0, enhanced_op_status[0]});
    end
    mz = 8'h00;
    u_host.wr(8'h20, mz);
    setc(9'd1);
    chk(8'(rdy), 8'h01);
    mo = 8'h40;
    @(posedge clk);
    ir <= 1'b1;
    @(posedge clk);
    ir <= 1'b0;
    rchk(8'h00, mz);
    u_host.wr(8'h00, mo);
    rchk(8'h21, mo);
    chk(8'(lvl), {5'h00, mz[6], mo[7:6]});
    u_host.wr(8'h51, 8'h02);
    u_host.wr(8'h50, 8'h03);
    setc(9'd31);
    chk({6'h00, rdy, irq}, 8'h00);
    setc(9'd32);
    chk({6'h00, rdy, irq}, 8'h03);
    rchk(8'h50, 8'h02);
    u_host.wr(8'h50, 8'h02);
    chk(8'(irq), 8'h00);
    {mz, mo} = 16'hc0c0;
    u_host.wr(8'h21, mo);
    u_host.wr(8'h67, 8'h80);
    setc(9'd1);
    u_host.wr(8'h20, mz);
    u_host.wr(8'h50, 8'h03);
    ticks(63);
    chk(8'(rdy), 8'h00);
    ticks(1);
    chk(8'(rdy), 8'h01);
    rchk(8'h50, 8'h01);
    @(posedge clk);
    acc <= 1'b1;
    @(posedge clk);
    acc <= 1'b0;
    ticks(63);
    chk(8'(rdy), 8'h00);
    @(posedge clk);
    {eq, subsystem_enable_status} <= 6'h30;
    @(posedge clk);
    sst <= 1'b1;
    @(posedge clk);
    {eq, sst} <= 2'b00;
    repeat (3) @(negedge clk);
    chk(8'(eact), 8'h01);
    @(posedge clk);
    td <= 1'b1;
    @(posedge clk);
    td <= 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(eact), 8'h00);
    test_done();
  end
endmodule

// file: rtl/usm_pkg.sv
// constants for the uart status and mode register group
package usm_pkg;

  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [7:0] ADDR_MODE_INDEXED  = 8'h00;
  localparam logic [7:0] ADDR_ENH_OP_STATUS = 8'h12;
  localparam logic [7:0] ADDR_MODE_ZERO     = 8'h20;
  localparam logic [7:0] ADDR_MODE_ONE      = 8'h21;
  localparam logic [7:0] ADDR_SUBSYS_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h50;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h51;
  localparam logic [7:0] ADDR_TEST_REV      = 8'h67;
  localparam logic [7:0] ADDR_PROD_TEST     = 8'h77;

  // test_and_revision fields
  localparam int TRR_BYPASS_BIT = 7;
  localparam int REV_MSB        = 6;

  // production_test_control fields
  localparam int PTC_MEM_BIT    = 2;
  localparam int PTC_SCAN_BIT   = 1;
  localparam int PTC_PULLUP_BIT = 0;
  localparam int PTC_MSB        = 2;

  // subsystem_enable_status fields
  localparam int SES_TX_BIT    = 5;
  localparam int SES_RX_BIT    = 4;
  localparam int SES_WDOG_BIT  = 3;
  localparam int SES_ADDR_BIT  = 2;
  localparam int SES_XON_BIT   = 1;
  localparam int SES_XOFF_BIT  = 0;

  // enhanced_op_status fields
  localparam int EOS_IO_BIT    = 6;
  localparam int EOS_CT0_BIT   = 4;
  localparam int EOS_CLK_BIT   = 2;
  localparam int EOS_LVL_BIT   = 0;

  // mode_zero / mode_one fields
  localparam int MZ_WDOG_BIT   = 7;
  localparam int MZ_LVL_HI_BIT = 6;
  localparam int MO_LVL_MSB    = 7;
  localparam int MO_LVL_LSB    = 6;

  // interrupt status / mask fields
  localparam int IRQ_WDOG_BIT  = 0;
  localparam int IRQ_LEVEL_BIT = 1;
  localparam int IRQ_MSB       = 1;

  // reset values
  localparam logic [7:0] RST_TEST_REV  = 8'h00;
  localparam logic [7:0] RST_PROD_TEST = 8'h00;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_IRQ       = 8'h00;

  // timing counts
  localparam int PRESCALE_DIV   = 16;
  localparam int WDOG_BIT_TIMES = 64;
  localparam int LEVEL_STEP     = 32;

  typedef enum logic [1:0] {
    ECHO_OFF,
    ECHO_ON,
    ECHO_DRAIN
  } usm_echo_t;

endpackage

// file: rtl/usm_regs.sv
// uart status, test and mode register group with watchdog and prescaler
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module usm_regs #(
  parameter int         FIFO_DEPTH = 256,
  parameter logic [6:0] REVISION   = 7'h15  // arbitrary value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // legacy mode index restart
  input  wire logic       mode_index_rst,
  // 16x clock enables in, bit clock enables out
  input  wire logic       tx_clk16_tick,
  input  wire logic       rx_clk16_tick,
  output logic            tx_bit_clock,
  output logic            rx_bit_clock,
  output logic            prescale_bypass,
  // production test controls
  output logic            mem_test_en,
  output logic            scan_test_en,
  output logic            pullup_en,
  // live subsystem state
  input  wire logic       tx_enabled,
  input  wire logic       rx_enabled,
  input  wire logic       addr_recog_on,
  input  wire logic       xon_on,
  input  wire logic       xoff_on,
  // enhanced operation state
  input  wire logic       io_enhanced,
  input  wire logic       ct0_clk_enhanced,
  input  wire logic       rxtx_clk_enhanced,
  input  wire logic       fifo_lvl_enhanced,
  // receive fifo
  input  wire logic [$clog2(FIFO_DEPTH+1)-1:0] rx_fifo_count,
  input  wire logic       rx_fifo_access,
  output logic            rx_char_ready,
  // echo mode handoff
  input  wire logic       echo_req,
  input  wire logic       rx_stop_sampled,
  input  wire logic       tx_stop_done,
  output logic            echo_active,
  // mode fields and interrupt
  output logic            wdog_enable,
  output logic      [2:0] rx_irq_level,
  output logic      [5:0] mode_zero_low,
  output logic            irq
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int WDW = $clog2(usm_pkg::WDOG_BIT_TIMES + 1);

  // refuse depths that the level thresholds and count width cannot serve
  if (FIFO_DEPTH < 8 || FIFO_DEPTH > 1024) begin : g_depth_chk
    $error("usm_regs: FIFO_DEPTH out of range");
  end

  // fill count that raises the receive request for a level
  function automatic logic [CW-1:0] level_thresh(input logic [2:0] lvl);
    logic [31:0] t;
    t = (lvl == 3'h0) ? 32'd1 : 32'(lvl) * 32'(usm_pkg::LEVEL_STEP);
    if (t > 32'(FIFO_DEPTH)) begin
      t = 32'(FIFO_DEPTH);
    end
    level_thresh = t[CW-1:0];
  endfunction

  // ---------------- software registers
  logic       test_bypass_ff, nxt_test_bypass;
  logic [2:0] prod_test_ff,   nxt_prod_test;
  logic [7:0] mode_zero_ff,   nxt_mode_zero;
  logic [7:0] mode_one_ff,    nxt_mode_one;
  logic       mode_index_ff,  nxt_mode_index;
  logic [1:0] irq_mask_ff,    nxt_irq_mask;
  logic [1:0] irq_stat_ff,    nxt_irq_stat;
  logic [7:0] rdata_ff,       nxt_rdata;

  logic       wdog_evt;
  logic       level_evt;
  logic       sel_mz;
  logic       sel_mo;
  logic [7:0] ses_val;
  logic [7:0] eos_val;

  // legacy location routes to mode_zero then mode_one
  always_comb begin
    sel_mz = (addr == usm_pkg::ADDR_MODE_ZERO) ||
             (addr == usm_pkg::ADDR_MODE_INDEXED && !mode_index_ff);
    sel_mo = (addr == usm_pkg::ADDR_MODE_ONE) ||
             (addr == usm_pkg::ADDR_MODE_INDEXED && mode_index_ff);
  end

  always_comb begin
    ses_val = 8'h00;
    ses_val[usm_pkg::SES_TX_BIT]   = tx_enabled;
    ses_val[usm_pkg::SES_RX_BIT]   = rx_enabled;
    ses_val[usm_pkg::SES_WDOG_BIT] = mode_zero_ff[usm_pkg::MZ_WDOG_BIT];
    ses_val[usm_pkg::SES_ADDR_BIT] = addr_recog_on;
    ses_val[usm_pkg::SES_XON_BIT]  = xon_on;
    ses_val[usm_pkg::SES_XOFF_BIT] = xoff_on;
    eos_val = 8'h00;
    eos_val[usm_pkg::EOS_IO_BIT]  = io_enhanced;
    eos_val[usm_pkg::EOS_CT0_BIT] = ct0_clk_enhanced;
    eos_val[usm_pkg::EOS_CLK_BIT] = rxtx_clk_enhanced;
    eos_val[usm_pkg::EOS_LVL_BIT] = fifo_lvl_enhanced;
  end

  always_comb begin
    nxt_test_bypass = test_bypass_ff;
    nxt_prod_test   = prod_test_ff;
    nxt_mode_zero   = mode_zero_ff;
    nxt_mode_one    = mode_one_ff;
    nxt_mode_index  = mode_index_ff;
    nxt_irq_mask    = irq_mask_ff;
    nxt_irq_stat    = irq_stat_ff;
    nxt_rdata       = 8'h00;
    if (wr_stb) begin
      // subsystem status and enhanced status addresses fall through unchanged
      case (addr)
        usm_pkg::ADDR_TEST_REV:
          nxt_test_bypass = wdata[usm_pkg::TRR_BYPASS_BIT];
        usm_pkg::ADDR_PROD_TEST:
          nxt_prod_test = wdata[usm_pkg::PTC_MSB:0];
        usm_pkg::ADDR_IRQ_MASK:
          nxt_irq_mask = wdata[usm_pkg::IRQ_MSB:0];
        usm_pkg::ADDR_IRQ_STATUS:
          nxt_irq_stat = irq_stat_ff & ~wdata[usm_pkg::IRQ_MSB:0];
        default: begin
        end
      endcase
      if (sel_mz) begin
        nxt_mode_zero = wdata;
      end
      if (sel_mo) begin
        nxt_mode_one = wdata;
      end
    end
    if (rd_stb) begin
      case (addr)
        usm_pkg::ADDR_TEST_REV:
          nxt_rdata = {test_bypass_ff, REVISION};
        usm_pkg::ADDR_PROD_TEST:
          nxt_rdata = {5'h00, prod_test_ff};
        usm_pkg::ADDR_SUBSYS_STATUS:
          nxt_rdata = ses_val;
        usm_pkg::ADDR_ENH_OP_STATUS:
          nxt_rdata = eos_val;
        usm_pkg::ADDR_IRQ_STATUS:
          nxt_rdata = {6'h00, irq_stat_ff};
        usm_pkg::ADDR_IRQ_MASK:
          nxt_rdata = {6'h00, irq_mask_ff};
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
      if (sel_mz) begin
        nxt_rdata = mode_zero_ff;
      end
      if (sel_mo) begin
        nxt_rdata = mode_one_ff;
      end
    end
    // legacy index steps once per access, then holds on mode_one
    if ((wr_stb || rd_stb) && addr == usm_pkg::ADDR_MODE_INDEXED) begin
      nxt_mode_index = 1'b1;
    end
    if (mode_index_rst) begin
      nxt_mode_index = 1'b0;
    end
    // hardware set wins over a same-cycle clear
    if (wdog_evt) begin
      nxt_irq_stat[usm_pkg::IRQ_WDOG_BIT] = 1'b1;
    end
    if (level_evt) begin
      nxt_irq_stat[usm_pkg::IRQ_LEVEL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_bypass_ff <= usm_pkg::RST_TEST_REV[usm_pkg::TRR_BYPASS_BIT];
      prod_test_ff   <= usm_pkg::RST_PROD_TEST[usm_pkg::PTC_MSB:0];
      mode_zero_ff   <= usm_pkg::RST_MODE;
      mode_one_ff    <= usm_pkg::RST_MODE;
      mode_index_ff  <= 1'b0;
      irq_mask_ff    <= usm_pkg::RST_IRQ[usm_pkg::IRQ_MSB:0];
      irq_stat_ff    <= usm_pkg::RST_IRQ[usm_pkg::IRQ_MSB:0];
      rdata_ff       <= 8'h00;
    end else begin
      test_bypass_ff <= nxt_test_bypass;
      prod_test_ff   <= nxt_prod_test;
      mode_zero_ff   <= nxt_mode_zero;
      mode_one_ff    <= nxt_mode_one;
      mode_index_ff  <= nxt_mode_index;
      irq_mask_ff    <= nxt_irq_mask;
      irq_stat_ff    <= nxt_irq_stat;
      rdata_ff       <= nxt_rdata;
    end
  end

  always_comb begin
    rdata           = rdata_ff;
    prescale_bypass = test_bypass_ff;
    mem_test_en     = prod_test_ff[usm_pkg::PTC_MEM_BIT];
    scan_test_en    = prod_test_ff[usm_pkg::PTC_SCAN_BIT];
    pullup_en       = !prod_test_ff[usm_pkg::PTC_PULLUP_BIT];
    wdog_enable     = mode_zero_ff[usm_pkg::MZ_WDOG_BIT];
    rx_irq_level    = {mode_zero_ff[usm_pkg::MZ_LVL_HI_BIT],
                       mode_one_ff[usm_pkg::MO_LVL_MSB:usm_pkg::MO_LVL_LSB]};
    mode_zero_low   = mode_zero_ff[5:0];
    irq             = |(irq_stat_ff & irq_mask_ff);
  end

  // ---------------- divide-by-16 prescalers
  logic [3:0] tx_div_ff, nxt_tx_div;
  logic [3:0] rx_div_ff, nxt_rx_div;
  logic       tx_wrap;
  logic       rx_wrap;
  localparam logic [3:0] DIV_LAST = 4'(usm_pkg::PRESCALE_DIV - 1);

  always_comb begin
    tx_wrap    = tx_clk16_tick && tx_div_ff == DIV_LAST;
    rx_wrap    = rx_clk16_tick && rx_div_ff == DIV_LAST;
    nxt_tx_div = tx_clk16_tick ? tx_div_ff + 4'h1 : tx_div_ff;
    nxt_rx_div = rx_clk16_tick ? rx_div_ff + 4'h1 : rx_div_ff;
    // bypass switches the path at once, mid-character included
    tx_bit_clock = test_bypass_ff ? tx_clk16_tick : tx_wrap;
    rx_bit_clock = test_bypass_ff ? rx_clk16_tick : rx_wrap;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_div_ff <= 4'h0;
      rx_div_ff <= 4'h0;
    end else begin
      tx_div_ff <= nxt_tx_div;
      rx_div_ff <= nxt_rx_div;
    end
  end

  // ---------------- receive watchdog and level request
  logic [WDW-1:0] wdog_cnt_ff, nxt_wdog_cnt;
  logic           lvl_req_ff,  nxt_lvl_req;
  logic           fifo_has_data;
  logic           lvl_now;
  localparam logic [WDW-1:0] WDOG_LAST = WDW'(usm_pkg::WDOG_BIT_TIMES);

  always_comb begin
    fifo_has_data = rx_fifo_count != '0;
    lvl_now       = rx_fifo_count >= level_thresh(rx_irq_level);
    nxt_lvl_req   = lvl_now;
    level_evt     = lvl_now && !lvl_req_ff;
    nxt_wdog_cnt  = wdog_cnt_ff;
    wdog_evt      = 1'b0;
    if (rx_fifo_access || !fifo_has_data || !wdog_enable) begin
      nxt_wdog_cnt = '0;
    end else if (rx_bit_clock && wdog_cnt_ff != WDOG_LAST) begin
      nxt_wdog_cnt = wdog_cnt_ff + WDW'(1);
      wdog_evt     = (wdog_cnt_ff + WDW'(1)) == WDOG_LAST;
    end
    rx_char_ready = lvl_req_ff || wdog_cnt_ff == WDOG_LAST;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_cnt_ff <= '0;
      lvl_req_ff  <= 1'b0;
    end else begin
      wdog_cnt_ff <= nxt_wdog_cnt;
      lvl_req_ff  <= nxt_lvl_req;
    end
  end

  // ---------------- echo mode release
  usm_pkg::usm_echo_t echo_ff, nxt_echo;
  logic               echo_char_ff, nxt_echo_char;

  always_comb begin
    nxt_echo      = echo_ff;
    nxt_echo_char = echo_char_ff;
    if (rx_stop_sampled) begin
      nxt_echo_char = 1'b1;
    end else if (tx_stop_done) begin
      nxt_echo_char = 1'b0;
    end
    case (echo_ff)
      usm_pkg::ECHO_OFF: begin
        if (echo_req) begin
          nxt_echo = usm_pkg::ECHO_ON;
        end
      end
      usm_pkg::ECHO_ON: begin
        if (!echo_req) begin
          // finish the character already being echoed
          if (tx_enabled && (echo_char_ff || rx_stop_sampled)) begin
            nxt_echo = usm_pkg::ECHO_DRAIN;
          end else begin
            nxt_echo = usm_pkg::ECHO_OFF;
          end
        end
      end
      usm_pkg::ECHO_DRAIN: begin
        if (tx_stop_done || !tx_enabled) begin
          nxt_echo      = echo_req ? usm_pkg::ECHO_ON : usm_pkg::ECHO_OFF;
          nxt_echo_char = 1'b0;
        end
      end
      default: begin
        nxt_echo = usm_pkg::ECHO_OFF;
      end
    endcase
    echo_active = echo_ff != usm_pkg::ECHO_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      echo_ff      <= usm_pkg::ECHO_OFF;
      echo_char_ff <= 1'b0;
    end else begin
      echo_ff      <= nxt_echo;
      echo_char_ff <= nxt_echo_char;
    end
  end

endmodule
